// ==== rtl/sars_defs.svh ====
// Contract
// R1: Run control high holds select high, output enable low, counters cleared.
// R2: In logic mode select goes high one converter clock in every twelve.
// R3: Twelve-bit framing counter and serial-in shift register capture the result.
// R4: Shift output enable is always the inverse of the converter select.
// R5: Converter clock may run at any rate up to the converter's maximum.
// R6: One converter clock sets both conversion rate and shift rate.
// R7: Command bits go out on the data input line, results return on output line.
// R8: Host launches and samples on the edge opposite to the converter's.
// R9: Frame pulse drives select directly; transmit to input, receive from output.
// R10: Transfers are sixteen bits; completion flagged only after the sixteenth bit.
// R11: Eight-bit command sits in the upper byte of the sixteen-bit word.
// R12: In serial port mode one conversion cycle takes twenty converter clocks.
// R13: Result is right-justified in the sixteen-bit receive word.
// R14: A new frame starts right after each capture while run control stays low; the code stalls instead while the result buffer is full.
`ifndef SARS_DEFS_SVH
`define SARS_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define SARS_SYS_PERIOD_NS 10
`define SARS_CONV_HALF_NS 100
`define SARS_HALF_CYC ((`SARS_CONV_HALF_NS + `SARS_SYS_PERIOD_NS - 1) / `SARS_SYS_PERIOD_NS)

// ****************************************
// Frame layout, in converter clocks
// ****************************************
`define SARS_LOGIC_PERIOD 12
`define SARS_LOGIC_ACTIVE 11
`define SARS_PORT_PERIOD 20
`define SARS_XFER_BITS 16
`define SARS_CMD_SHIFT 8
`define SARS_RESULT_BITS 8

`endif

// ==== rtl/sars_pkg.sv ====
package sars_pkg;

  // Which far-side arrangement is sequenced
  typedef enum logic {
    SARS_MODE_LOGIC = 1'b0,
    SARS_MODE_PORT = 1'b1
  } sars_mode_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SARS_ST_HOLD = 3'b001,
    SARS_ST_FRAME = 3'b010,
    SARS_ST_STALL = 3'b100
  } sars_state_t;

  // Pins driven toward the converter and the parallel register
  typedef struct packed {
    logic conv_clk;
    logic conv_cs_n;
    logic shift_out_en;
    logic host_transmit_line;
  } sars_link_t;

endpackage

// ==== rtl/sars_skid_buf.sv ====
`timescale 1ns/1ns
`include "sars_defs.svh"

module sars_skid_buf
  import sars_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [`SARS_RESULT_BITS-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [`SARS_RESULT_BITS-1:0] out_data,
  input wire logic out_ready
);

  logic [`SARS_RESULT_BITS-1:0] slot_reg [2];
  logic head_v_reg;
  logic tail_v_reg;
  logic push;
  logic pop;

  // Handshake terms
  assign push = in_valid && !tail_v_reg;
  assign pop = head_v_reg && out_ready;
  assign in_ready = !tail_v_reg;
  assign out_valid = head_v_reg;
  assign out_data = slot_reg[0];

  // Head entry, presented to the reader
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      head_v_reg <= 1'b0;
      slot_reg[0] <= 8'h00;
    end else if (pop) begin
      if (tail_v_reg) begin
        slot_reg[0] <= slot_reg[1];
      end else if (push) begin
        slot_reg[0] <= in_data;
      end else begin
        head_v_reg <= 1'b0;
      end
    end else if (!head_v_reg && push) begin
      slot_reg[0] <= in_data;
      head_v_reg <= 1'b1;
    end
  end

  // Tail entry, catches a word while the reader stalls
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tail_v_reg <= 1'b0;
      slot_reg[1] <= 8'h00;
    end else if (pop) begin
      tail_v_reg <= 1'b0;
    end else if (head_v_reg && push) begin
      slot_reg[1] <= in_data;
      tail_v_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_buf_hold_data: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Buffer head changed while stalled");
  a_buf_full_refuse: assert property (tail_v_reg && !pop |=> tail_v_reg && $stable(slot_reg[1]))
    else $error("Full buffer lost its tail word");
  c_buf_fills: cover property (tail_v_reg && head_v_reg);

endmodule

// ==== rtl/sars_sequencer.sv ====
`timescale 1ns/1ns
`include "sars_defs.svh"

module sars_sequencer
  import sars_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_run_control,
  input wire logic mode_port,
  input wire logic [7:0] chan_cmd,
  input wire logic host_receive_line,
  output sars_link_t link,
  output logic receive_done_irq,
  output logic [`SARS_RESULT_BITS-1:0] parallel_result_bits,
  output logic result_valid,
  input wire logic result_ready
);

  // ****************************************
  // Declarations
  // ****************************************
  sars_state_t state_reg;
  sars_state_t state_next;
  sars_mode_t mode_reg;
  logic [7:0] div_reg;
  logic conv_clk_reg;
  logic rise_en;
  logic fall_en;
  logic [11:0] frame_cnt_reg;
  logic cs_n_reg;
  logic oe_reg;
  logic din_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic dout_meta_reg;
  logic dout_sync_reg;
  logic done_reg;
  logic push_reg;
  logic buf_ready;
  logic [11:0] period;
  logic [11:0] active;
  logic frame_end;

  // Frame geometry for the latched mode
  function automatic logic [11:0] frame_len(input sars_mode_t m, input logic want_active);
    frame_len = 12'h000;
    if (m == SARS_MODE_PORT) begin
      frame_len = want_active ? 12'(`SARS_XFER_BITS) : 12'(`SARS_PORT_PERIOD);
    end else begin
      frame_len = want_active ? 12'(`SARS_LOGIC_ACTIVE) : 12'(`SARS_LOGIC_PERIOD);
    end
  endfunction

  assign period = frame_len(mode_reg, 1'b0); // [R2] [R12]
  assign active = frame_len(mode_reg, 1'b1);
  assign frame_end = (frame_cnt_reg == period - 12'h001);

  // ****************************************
  // Converter clock divider
  // ****************************************
  // One divider gives the single converter clock; all shifting follows it [R5] [R6]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg <= 8'h00;
      conv_clk_reg <= 1'b0;
    end else if (div_reg == 8'(`SARS_HALF_CYC - 1)) begin
      div_reg <= 8'h00;
      conv_clk_reg <= !conv_clk_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Edge enables, one cycle before the clock pin changes
  assign rise_en = (div_reg == 8'(`SARS_HALF_CYC - 1)) && !conv_clk_reg;
  assign fall_en = (div_reg == 8'(`SARS_HALF_CYC - 1)) && conv_clk_reg;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // Converter data out passes two flops before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout_meta_reg <= 1'b0;
      dout_sync_reg <= 1'b0;
    end else begin
      dout_meta_reg <= host_receive_line;
      dout_sync_reg <= dout_meta_reg;
    end
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  // Next state: hold while run control is high, stall when no buffer room
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SARS_ST_HOLD: begin
        if (!host_run_control && fall_en && buf_ready) begin
          state_next = SARS_ST_FRAME;
        end
      end
      SARS_ST_FRAME: begin
        if (host_run_control) begin
          state_next = SARS_ST_HOLD; // [R1]
        end else if (fall_en && frame_end && !buf_ready) begin
          state_next = SARS_ST_STALL;
        end
      end
      SARS_ST_STALL: begin
        if (host_run_control) begin
          state_next = SARS_ST_HOLD;
        end else if (fall_en && buf_ready) begin
          state_next = SARS_ST_FRAME;
        end
      end
      default: begin
        state_next = SARS_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= SARS_ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Mode is taken only while held, so a frame never changes shape midway
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= SARS_MODE_LOGIC;
    end else if (state_reg == SARS_ST_HOLD) begin
      mode_reg <= sars_mode_t'(mode_port);
    end
  end

  // ****************************************
  // Framing counter and select
  // ****************************************
  // Counter advances on converter falling edges; wraps straight into a new frame unless the result buffer is full, then stalls [R3] [R14]
  always_ff @(posedge sys_clk) begin
    if (rst || host_run_control) begin
      frame_cnt_reg <= 12'h000; // [R1]
      cs_n_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else if (fall_en) begin
      if (state_next == SARS_ST_FRAME && (state_reg != SARS_ST_FRAME || frame_end)) begin
        frame_cnt_reg <= 12'h000;
        cs_n_reg <= 1'b0; // [R9]
        oe_reg <= 1'b1; // [R4]
      end else if (state_reg == SARS_ST_FRAME) begin
        frame_cnt_reg <= frame_cnt_reg + 12'h001;
        cs_n_reg <= (frame_cnt_reg + 12'h001 >= active); // [R2]
        oe_reg <= !(frame_cnt_reg + 12'h001 >= active); // [R4]
      end
    end
  end

  // ****************************************
  // Command shifting
  // ****************************************
  // Command byte sits in the upper byte, launched MSB first on falling edges [R7] [R8] [R11]
  always_ff @(posedge sys_clk) begin
    if (rst || host_run_control) begin
      tx_reg <= 16'h0000;
      din_reg <= 1'b0;
    end else if (fall_en) begin
      if (state_next == SARS_ST_FRAME && (state_reg != SARS_ST_FRAME || frame_end)) begin
        tx_reg <= {chan_cmd, 8'h00} << 1; // [R11]
        din_reg <= chan_cmd[7];
      end else begin
        tx_reg <= tx_reg << 1;
        din_reg <= tx_reg[15];
      end
    end
  end

  // ****************************************
  // Result capture
  // ****************************************
  // Sample on rising edges while selected; completion after the last bit [R3] [R8] [R10]
  always_ff @(posedge sys_clk) begin
    if (rst || host_run_control) begin
      rx_reg <= 16'h0000;
      done_reg <= 1'b0;
      push_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      push_reg <= 1'b0;
      if (rise_en && state_reg == SARS_ST_FRAME && frame_cnt_reg < active) begin
        rx_reg <= {rx_reg[14:0], dout_sync_reg};
        if (frame_cnt_reg == active - 12'h001) begin
          done_reg <= (mode_reg == SARS_MODE_PORT); // [R10]
          push_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Result buffer
  // ****************************************
  // Low byte of the receive word is the right-justified result [R13]
  sars_skid_buf u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push_reg),
    .in_data(rx_reg[7:0]),
    .in_ready(buf_ready),
    .out_valid(result_valid),
    .out_data(parallel_result_bits),
    .out_ready(result_ready)
  );

  // Output wiring from flops, one driver for the whole link struct
  assign link = '{conv_clk: conv_clk_reg, conv_cs_n: cs_n_reg, shift_out_en: oe_reg,
                  host_transmit_line: din_reg};
  assign receive_done_irq = done_reg;

  // ****************************************
  // Checks
  // ****************************************
  // Helper for the half-period check: cycles the converter clock held its level
  logic clk_last_reg;
  logic clk_seen_reg;
  logic [7:0] clk_run_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_last_reg <= 1'b0;
      clk_seen_reg <= 1'b0;
      clk_run_reg <= 8'h00;
    end else if (conv_clk_reg != clk_last_reg) begin
      clk_last_reg <= conv_clk_reg;
      clk_seen_reg <= 1'b1; // First level after reset is not a full half period
      clk_run_reg <= 8'h00;
    end else begin
      clk_run_reg <= clk_run_reg + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_run_hold_select: assert property (host_run_control |=> cs_n_reg && !oe_reg) // [R1]
    else $error("Select not held high under run control");
  a_oe_inverse_sel: assert property (oe_reg == !cs_n_reg) // [R4]
    else $error("Output enable is not inverse of select");
  a_logic_one_high: assert property (fall_en && state_reg == SARS_ST_FRAME // [R2]
      && mode_reg == SARS_MODE_LOGIC && frame_cnt_reg == 12'(`SARS_LOGIC_ACTIVE - 1)
      |=> cs_n_reg ##(2 * `SARS_HALF_CYC) !cs_n_reg || host_run_control
      || state_reg != SARS_ST_FRAME)
    else $error("Select high not exactly one clock per twelve");
  a_port_period: assert property (fall_en && state_reg == SARS_ST_FRAME // [R12]
      && mode_reg == SARS_MODE_PORT && !frame_end
      |=> frame_cnt_reg < 12'(`SARS_PORT_PERIOD))
    else $error("Port frame exceeded twenty clocks");
  a_done_sixteen: assert property (done_reg // [R10]
      |-> frame_cnt_reg == 12'(`SARS_XFER_BITS - 1) && mode_reg == SARS_MODE_PORT)
    else $error("Completion before sixteenth bit");
  a_cmd_upper: assert property (fall_en && state_reg != SARS_ST_FRAME // [R11]
      && state_next == SARS_ST_FRAME |=> din_reg == $past(chan_cmd[7])
      && tx_reg[7:0] == 8'h00)
    else $error("Command not placed in upper byte");
  a_launch_falling: assert property ($changed(din_reg) // [R8]
      |-> $past(fall_en) || $past(host_run_control))
    else $error("Command bit launched off the falling edge");
  a_clk_half: assert property (clk_seen_reg && conv_clk_reg != clk_last_reg // [R6]
      |-> clk_run_reg == 8'(`SARS_HALF_CYC - 1))
    else $error("Converter clock half period wrong");
  a_back_to_back: assert property (fall_en && frame_end && state_reg == SARS_ST_FRAME // [R14]
      && buf_ready && !host_run_control |=> !cs_n_reg && frame_cnt_reg == 12'h000)
    else $error("New frame did not follow capture");

  c_logic_frame: cover property (push_reg && mode_reg == SARS_MODE_LOGIC);
  c_port_frame: cover property (done_reg);
  c_stall: cover property (state_reg == SARS_ST_STALL);
  c_run_abort: cover property (state_reg == SARS_ST_FRAME && host_run_control);

endmodule

// ==== testbench/sars_conv_model.sv ====
`timescale 1ns/1ns

module sars_conv_model
  import sars_pkg::*;
(
  input wire logic sys_clk,
  input wire logic mode_port,
  input wire sars_link_t link,
  input wire logic [7:0] next_byte,
  output logic host_receive_line,
  output logic frame_start,
  output logic [7:0] frame_byte,
  output logic frame_end,
  output logic [15:0] cmd_word
);
  logic clk_prev = 1'b0;
  logic cs_prev = 1'b1;
  int bit_idx = 0;
  int n_rise = 0;
  int n_bits;

  initial begin
    host_receive_line = 1'b0;
    frame_start = 1'b0;
    frame_byte = 8'h00;
    frame_end = 1'b0;
    cmd_word = 16'h0000;
  end

  // ****************************************
  // Converter pins, seen at the settled half
  // ****************************************
  // One converter clock paces both the frame and the shifting
  always @(negedge sys_clk) begin
    n_bits = mode_port ? 16 : 11;
    frame_start = 1'b0;
    frame_end = 1'b0;
    if (link.conv_cs_n) begin
      if (!cs_prev && n_rise == 16) begin
        frame_end = 1'b1;
      end
      host_receive_line = ~host_receive_line; // Deselected output never holds
    end else if (clk_prev && !link.conv_clk) begin
      if (cs_prev) begin
        frame_byte = next_byte;
        frame_start = 1'b1;
        bit_idx = 0;
        n_rise = 0;
        cmd_word = 16'h0000;
      end
      if (bit_idx >= n_bits - 8 && bit_idx < n_bits) begin
        host_receive_line = frame_byte[n_bits - 1 - bit_idx];
      end else begin
        host_receive_line = bit_idx[0];
      end
      bit_idx++;
    end else if (!clk_prev && link.conv_clk) begin
      cmd_word = {cmd_word[14:0], link.host_transmit_line};
      n_rise++;
    end
    clk_prev = link.conv_clk;
    cs_prev = link.conv_cs_n;
  end
endmodule

// ==== testbench/serial_adc_readout_sequencer_test.sv ====
`timescale 1ns/1ns
`include "sars_defs.svh"

module serial_adc_readout_sequencer_test
  import sars_pkg::*;
  ;
  localparam int HALF = `SARS_HALF_CYC;
  localparam int CEIL = 30000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic host_run_control = 1'b1;
  logic mode_port = 1'b0;
  logic [7:0] chan_cmd = 8'h00;
  logic host_receive_line;
  sars_link_t link;
  logic receive_done_irq;
  logic [7:0] parallel_result_bits;
  logic result_valid;
  logic result_ready = 1'b1;
  logic [7:0] next_byte = 8'h5a;
  logic frame_start;
  logic frame_end;
  logic [7:0] frame_byte;
  logic [15:0] cmd_word;
  logic [7:0] expq[$];
  logic chk_per = 1'b0;
  logic lo_seen = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int lo_len = 0;
  int hi_len = 0;
  int n_done = 0;
  int n_pop = 0;

  sars_sequencer uut (
    .sys_clk(sys_clk), .rst(rst), .host_run_control(host_run_control),
    .mode_port(mode_port), .chan_cmd(chan_cmd), .host_receive_line(host_receive_line),
    .link(link), .receive_done_irq(receive_done_irq),
    .parallel_result_bits(parallel_result_bits), .result_valid(result_valid),
    .result_ready(result_ready)
  );

  sars_conv_model conv (
    .sys_clk(sys_clk), .mode_port(mode_port), .link(link), .next_byte(next_byte),
    .host_receive_line(host_receive_line), .frame_start(frame_start),
    .frame_byte(frame_byte), .frame_end(frame_end), .cmd_word(cmd_word)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Select low or high time in system cycles
  function automatic logic [15:0] span(input logic low);
    int conv;
    if (mode_port) conv = low ? `SARS_XFER_BITS : `SARS_PORT_PERIOD - `SARS_XFER_BITS;
    else conv = low ? `SARS_LOGIC_ACTIVE : `SARS_LOGIC_PERIOD - `SARS_LOGIC_ACTIVE;
    return 16'(conv * 2 * HALF);
  endfunction

  task automatic frames(input int n);
    repeat (n) @(posedge frame_start);
    @(negedge sys_clk);
  endtask

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Watchers: timeout, framing, expected notes, results
  // ****************************************
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == CEIL) begin
      n_mismatch++;
      conclude();
    end
    if (!rst) begin
      check("oe_vs_select", link.shift_out_en, !link.conv_cs_n);
      if (receive_done_irq) n_done++;
      if (!link.conv_cs_n) begin
        if (hi_len > 0 && lo_seen && chk_per) begin
          check("select_high", hi_len[15:0], span(0));
        end
        hi_len = 0;
        lo_len++;
      end else begin
        if (lo_len > 0 && !host_run_control) begin
          check("select_low", lo_len[15:0], span(1));
          lo_seen = 1'b1;
        end
        lo_len = 0;
        hi_len++;
      end
      if (host_run_control) lo_seen = 1'b0;
      if (frame_start) begin
        expq.push_back(frame_byte);
        next_byte <= 8'($urandom);
      end
      if (frame_end && mode_port) begin
        check("command_word", cmd_word, {chan_cmd, 8'h00});
      end
      if (result_valid === 1'b1 && result_ready) begin
        n_pop++;
        if (expq.size() == 0) check("result_extra", 16'h0001, 16'h0000);
        else check("result_byte", parallel_result_bits, expq.pop_front());
        if (!mode_port) check("done_logic", n_done[15:0], 16'h0000);
        else if (chk_per) check("done_count", n_done[15:0], n_pop[15:0]);
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(2486));
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("hold_select", link.conv_cs_n, 1'b1);
    check("hold_enable", link.shift_out_en, 1'b0);
    // Logic arrangement, reader always ready
    host_run_control = 1'b0;
    chk_per = 1'b1;
    frames(6);
    // Reader ready at random
    chk_per = 1'b0;
    for (int i = 0; i < 1500; i++) begin
      @(negedge sys_clk);
      result_ready = 1'($urandom);
    end
    result_ready = 1'b1;
    repeat (10) @(negedge sys_clk);
    // Reader stalls until both slots fill, framing must stop
    result_ready = 1'b0;
    repeat (6 * 24 * HALF) @(negedge sys_clk);
    check("pending_words", 16'(expq.size()), 16'h0002);
    check("stalled_select", link.conv_cs_n, 1'b1);
    result_ready = 1'b1;
    frames(2);
    // Hold in mid-frame
    repeat (37) @(negedge sys_clk);
    host_run_control = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      check("hold_select", link.conv_cs_n, 1'b1);
      check("hold_enable", link.shift_out_en, 1'b0);
    end
    // Serial port arrangement
    expq.delete();
    n_done = 0;
    n_pop = 0;
    mode_port = 1'b1;
    chan_cmd = 8'($urandom);
    host_run_control = 1'b0;
    chk_per = 1'b1;
    frames(5);
    repeat (50) @(negedge sys_clk);
    conclude();
  end
endmodule
